/* File: design/pt_timer.sv */
// How it works
// - Timer clock is the instruction tick, one in four system clocks.
// - Count register steps by one from zero on each prescaled tick.
// - Control bits 1-0 pick prescale ratio 1, 4, 16 or 64.
// - Count compared with period each timer tick; equality gives match output.
// - On match the count returns to zero and the postscaler advances.
// - Reset clears the count and sets the period to all ones.
// - Count or control writes and every reset clear prescaler and postscaler.
// - A control write leaves the count value untouched.
// - Software reads and writes count and period at any time.
// - Four-bit postscaler counts matches and then latches the match flag.
// - Control bits 6-3 value n selects postscale ratio n plus one.
// - Flag at bit 1 of flag register, enable at bit 1 of enable register.
// - Match output is synchronous to the system clock.
// - During sleep the timer stops; count and period keep their values.
// - Control bit 2 runs the timer; bit 7 reads zero.
`timescale 1ns/1ps
module pt_timer (
    input  wire logic       clk,         // System oscillator, 20 MHz
    input  wire logic       reset_n,     // Asynchronous reset, active low
    input  wire logic [2:0] addr,        // Register index
    input  wire logic [7:0] wdata,       // Write data
    input  wire logic       wrEn,        // Write strobe
    input  wire logic       rdEn,        // Read strobe
    output logic      [7:0] rdata,       // Read data, cycle after strobe
    input  wire logic       sleepReq,    // Processor sleep level
    output logic            periodMatch, // One-cycle match pulse
    output logic            irq          // Level interrupt request
);

    logic                rstMeta;
    logic                rstN;
    pt_pkg::pt_state_s   s;
    pt_pkg::pt_state_s   next_s;
    logic                instTick;
    logic                run;
    logic [5:0]          preLim;
    logic                timerTick;
    logic                isMatch;
    logic                setFlag;
    logic                wrCount;
    logic                wrCtrl;
    logic                rdFlag;
    logic                wrPeriod;
    logic                wrEnable;
    logic                rdCount;
    logic                rdPeriod;
    logic                rdCtrl;
    logic                rdEnable;

    // Reset released through two flops so every flop leaves reset together
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    assign run       = s.ctrl[pt_pkg::ON_BIT] && !s.sleepSync;
    assign instTick  = (s.phase == pt_pkg::PHASE_LAST);
    assign timerTick = run && instTick && (s.pre == preLim);
    assign isMatch   = (s.count == s.period);
    assign setFlag   = timerTick && isMatch
                       && (s.post == s.ctrl[pt_pkg::POST_MSB:pt_pkg::POST_LSB]);
    assign wrCount   = wrEn && (addr == pt_pkg::ADDR_COUNT);
    assign wrCtrl    = wrEn && (addr == pt_pkg::ADDR_CTRL);
    assign rdFlag    = rdEn && (addr == pt_pkg::ADDR_FLAG);
    assign wrPeriod  = wrEn && (addr == pt_pkg::ADDR_PERIOD);
    assign wrEnable  = wrEn && (addr == pt_pkg::ADDR_ENABLE);
    assign rdCount   = rdEn && (addr == pt_pkg::ADDR_COUNT);
    assign rdPeriod  = rdEn && (addr == pt_pkg::ADDR_PERIOD);
    assign rdCtrl    = rdEn && (addr == pt_pkg::ADDR_CTRL);
    assign rdEnable  = rdEn && (addr == pt_pkg::ADDR_ENABLE);

    always_comb begin
        case (s.ctrl[pt_pkg::PRE_MSB:pt_pkg::PRE_LSB])
            2'h0:    preLim = pt_pkg::PRE_LIM_1;
            2'h1:    preLim = pt_pkg::PRE_LIM_4;
            2'h2:    preLim = pt_pkg::PRE_LIM_16;
            default: preLim = pt_pkg::PRE_LIM_64;
        endcase
    end

    always_comb begin
        next_s           = s;
        next_s.sleepMeta = sleepReq;
        next_s.sleepSync = s.sleepMeta;
        next_s.matchOut  = 1'b0;
        next_s.rdata     = pt_pkg::DATA_ZERO;

        // Phase frozen while stopped so a restart resumes the part-done tick
        if (run) begin
            next_s.phase = s.phase + 2'h1;
        end
        if (run && instTick) begin
            if (timerTick) begin
                next_s.pre = 6'h00;
            end else begin
                next_s.pre = s.pre + 6'h01;
            end
        end

        if (timerTick) begin
            if (isMatch) begin
                next_s.count    = pt_pkg::COUNT_RST;
                next_s.matchOut = 1'b1;
                if (setFlag) begin
                    next_s.post = 4'h0;
                end else begin
                    next_s.post = s.post + 4'h1;
                end
            end else begin
                next_s.count = s.count + 8'h01;
            end
        end

        // Software writes override the timer in the same cycle
        if (wrCount) begin
            next_s.count = wdata;
            next_s.pre   = 6'h00;
            next_s.post  = 4'h0;
        end else if (wrPeriod) begin
            next_s.period = wdata;
        end else if (wrCtrl) begin
            next_s.ctrl  = wdata[pt_pkg::CTRL_MSB:0];
            next_s.count = s.count;
            next_s.pre   = 6'h00;
            next_s.post  = 4'h0;
        end else if (wrEnable) begin
            next_s.enable = wdata[pt_pkg::FLAG_BIT];
        end

        if (rdEn) begin
            if (addr == pt_pkg::ADDR_COUNT) begin
                next_s.rdata = s.count;
            end else if (addr == pt_pkg::ADDR_PERIOD) begin
                next_s.rdata = s.period;
            end else if (addr == pt_pkg::ADDR_CTRL) begin
                next_s.rdata = {1'b0, s.ctrl};
            end else if (addr == pt_pkg::ADDR_FLAG) begin
                next_s.rdata[pt_pkg::FLAG_BIT] = s.flag;
            end else if (addr == pt_pkg::ADDR_ENABLE) begin
                next_s.rdata[pt_pkg::FLAG_BIT] = s.enable;
            end
        end

        // Reading the flag register clears it; a flag set by the postscaler in the same cycle wins
        if (rdFlag) begin
            next_s.flag = 1'b0;
        end
        if (setFlag) begin
            next_s.flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s           <= '0;
            s.count     <= pt_pkg::COUNT_RST;
            s.period    <= pt_pkg::PERIOD_RST;
            s.ctrl      <= pt_pkg::CTRL_RST;
            s.pre       <= 6'h00;
            s.post      <= 4'h0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata       = s.rdata;
    assign periodMatch = s.matchOut;
    assign irq         = s.flag && s.enable;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    sequence s_tick;
        instTick ##1 !instTick [*3] ##1 instTick;
    endsequence

    property p_inst_div;
        run && instTick ##1 run [*3] |-> ##1 instTick;
    endproperty
    a_inst_div: assert property (p_inst_div) else $error("instruction tick not every 4");

    property p_step;
        timerTick && !isMatch && !wrEn |=> s.count == $past(s.count) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("count did not step by one");

    property p_pre64;
        timerTick && s.ctrl[pt_pkg::PRE_MSB:pt_pkg::PRE_LSB] == 2'h3
            |-> s.pre == pt_pkg::PRE_LIM_64;
    endproperty
    a_pre64: assert property (p_pre64) else $error("prescale 64 terminal wrong");

    sequence s_match_hit;
        timerTick && isMatch && !wrEn;
    endsequence

    property p_wrap;
        s_match_hit |=> periodMatch && s.count == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("match did not wrap count");

    property p_match_cause;
        periodMatch |-> $past(timerTick) && $past(s.count == s.period);
    endproperty
    a_match_cause: assert property (p_match_cause) else $error("match without cause");

    property p_clear_scalers;
        wrCount || wrCtrl |=> s.pre == 6'h00 && s.post == 4'h0;
    endproperty
    a_clear_scalers: assert property (p_clear_scalers) else $error("scalers not cleared");

    property p_ctrl_keeps;
        wrCtrl |=> s.count == $past(s.count);
    endproperty
    a_ctrl_keeps: assert property (p_ctrl_keeps) else $error("control write moved count");

    property p_hold;
        !run && !wrEn |=> $stable(s.count) && $stable(s.pre) && !periodMatch;
    endproperty
    a_hold: assert property (p_hold) else $error("timer moved while stopped");

    property p_post;
        setFlag |=> s.flag && s.post == 4'h0;
    endproperty
    a_post: assert property (p_post) else $error("postscaler did not latch flag");

    property p_sticky;
        s.flag && !rdFlag |=> s.flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without clear");

    property p_irq;
        s.flag && !s.enable |-> !irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without enable");

    property p_bit7;
        rdEn && addr == pt_pkg::ADDR_CTRL |=> rdata[7] == 1'b0;
    endproperty
    a_bit7: assert property (p_bit7) else $error("control bit 7 not zero");

    property p_rd_idle;
        !rdEn |=> rdata == pt_pkg::DATA_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

    property p_rd_count;
        rdCount |=> rdata == $past(s.count);
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("count read wrong");

    property p_rd_period;
        rdPeriod |=> rdata == $past(s.period);
    endproperty
    a_rd_period: assert property (p_rd_period) else $error("period read wrong");

    property p_rd_ctrl;
        rdCtrl |=> rdata[pt_pkg::CTRL_MSB:0] == $past(s.ctrl);
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

    property p_rd_flag;
        rdFlag |=> rdata[pt_pkg::FLAG_BIT] == $past(s.flag);
    endproperty
    a_rd_flag: assert property (p_rd_flag) else $error("flag read wrong");

    property p_rd_flag_bits;
        rdFlag |=> rdata[7:2] == 6'h00 && rdata[0] == 1'b0;
    endproperty
    a_rd_flag_bits: assert property (p_rd_flag_bits) else $error("flag spare bits set");

    property p_rd_enable;
        rdEnable |=> rdata[pt_pkg::FLAG_BIT] == $past(s.enable);
    endproperty
    a_rd_enable: assert property (p_rd_enable) else $error("enable read wrong");

    property p_rd_unmapped;
        rdEn && addr > pt_pkg::ADDR_ENABLE |=> rdata == pt_pkg::DATA_ZERO;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_wr_count;
        wrCount |=> s.count == $past(wdata);
    endproperty
    a_wr_count: assert property (p_wr_count) else $error("count write lost");

    property p_wr_period;
        wrPeriod |=> s.period == $past(wdata);
    endproperty
    a_wr_period: assert property (p_wr_period) else $error("period write lost");

    property p_wr_ctrl;
        wrCtrl |=> s.ctrl == $past(wdata[pt_pkg::CTRL_MSB:0]);
    endproperty
    a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write lost");

    property p_wr_enable;
        wrEnable |=> s.enable == $past(wdata[pt_pkg::FLAG_BIT]);
    endproperty
    a_wr_enable: assert property (p_wr_enable) else $error("enable write lost");

    property p_wr_flag_ignored;
        wrEn && addr == pt_pkg::ADDR_FLAG && !setFlag && !s.flag |=> !s.flag;
    endproperty
    a_wr_flag_ignored: assert property (p_wr_flag_ignored) else $error("flag set by write");

    property p_period_keep;
        !wrPeriod |=> $stable(s.period);
    endproperty
    a_period_keep: assert property (p_period_keep) else $error("period moved");

    property p_sleep_hold;
        s.sleepSync && !wrEn |=> $stable(s.count) && $stable(s.post);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("timer ran in sleep");

    property p_sleep_run;
        s.sleepSync |-> !run;
    endproperty
    a_sleep_run: assert property (p_sleep_run) else $error("run high in sleep");

    property p_stop_hold;
        !run && !wrEn |=> $stable(s.post) && $stable(s.phase);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("scalers moved stopped");

    property p_phase_step;
        run |=> s.phase == $past(s.phase) + 2'h1;
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase did not step");

    property p_pre1;
        timerTick && s.ctrl[pt_pkg::PRE_MSB:pt_pkg::PRE_LSB] == 2'h0
            |-> s.pre == pt_pkg::PRE_LIM_1;
    endproperty
    a_pre1: assert property (p_pre1) else $error("prescale 1 terminal wrong");

    property p_pre4;
        timerTick && s.ctrl[pt_pkg::PRE_MSB:pt_pkg::PRE_LSB] == 2'h1
            |-> s.pre == pt_pkg::PRE_LIM_4;
    endproperty
    a_pre4: assert property (p_pre4) else $error("prescale 4 terminal wrong");

    property p_pre16;
        timerTick && s.ctrl[pt_pkg::PRE_MSB:pt_pkg::PRE_LSB] == 2'h2
            |-> s.pre == pt_pkg::PRE_LIM_16;
    endproperty
    a_pre16: assert property (p_pre16) else $error("prescale 16 terminal wrong");

    property p_match_one;
        periodMatch |=> !periodMatch;
    endproperty
    a_match_one: assert property (p_match_one) else $error("match longer than one cycle");

    property p_post_step;
        s_match_hit && !setFlag |=> s.post == $past(s.post) + 4'h1;
    endproperty
    a_post_step: assert property (p_post_step) else $error("postscaler did not step");

    property p_flag_cause;
        $rose(s.flag) |-> $past(setFlag);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without count");

    property p_flag_free;
        setFlag && !s.enable |=> s.flag;
    endproperty
    a_flag_free: assert property (p_flag_free) else $error("flag gated by enable");

    property p_read_clear;
        rdFlag && !setFlag |=> !s.flag;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag read did not clear");

    property p_irq_on;
        s.flag && s.enable |-> irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

endmodule

/* File: pkg/pt_pkg.sv */
package pt_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] ADDR_COUNT  = 3'h0;
    localparam logic [2:0] ADDR_PERIOD = 3'h1;
    localparam logic [2:0] ADDR_CTRL   = 3'h2;
    localparam logic [2:0] ADDR_FLAG   = 3'h3;
    localparam logic [2:0] ADDR_ENABLE = 3'h4;

    // System oscillator rate and instruction clock division
    localparam int         CLK_HZ      = 20000000;
    localparam int         INST_DIV    = 4;
    localparam logic [1:0] PHASE_LAST  = 2'(INST_DIV - 1);

    // Control register fields
    localparam int PRE_LSB   = 0;
    localparam int PRE_MSB   = 1;
    localparam int ON_BIT    = 2;
    localparam int POST_LSB  = 3;
    localparam int POST_MSB  = 6;
    localparam int CTRL_MSB  = 6;

    // Match flag and its enable share this bit position
    localparam int FLAG_BIT  = 1;

    // Prescaler terminal counts for ratios 1, 4, 16, 64
    localparam logic [5:0] PRE_LIM_1  = 6'h00;
    localparam logic [5:0] PRE_LIM_4  = 6'h03;
    localparam logic [5:0] PRE_LIM_16 = 6'h0F;
    localparam logic [5:0] PRE_LIM_64 = 6'h3F;

    // Reset values
    localparam logic [7:0] COUNT_RST  = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [6:0] CTRL_RST   = 7'h00;
    localparam logic [7:0] DATA_ZERO  = 8'h00;

    typedef struct packed {
        logic       sleepMeta;
        logic       sleepSync;
        logic [1:0] phase;
        logic [5:0] pre;
        logic [3:0] post;
        logic [7:0] count;
        logic [7:0] period;
        logic [6:0] ctrl;
        logic       flag;
        logic       enable;
        logic       matchOut;
        logic [7:0] rdata;
    } pt_state_s;

endpackage

/* File: testbench/pt_timer_bench.sv */
`timescale 1ns/1ps
module pt_timer_bench;
    logic       clk;
    logic       reset_n;
    logic       wrEn;
    logic       rdEn;
    logic       sleepReq;
    logic       periodMatch;
    logic       irq;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] expReg [8];
    logic [7:0] wMask  [8];
    int         nErrors;
    int         checkCount;
    int         cyc;
    int         matchCnt;
    int         lastMatch;
    int         p;
    int         n;
    int         t1;

    pt_timer u_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wrEn(wrEn),
        .rdEn(rdEn), .rdata(rdata), .sleepReq(sleepReq), .periodMatch(periodMatch), .irq(irq));

    always #25 clk = ~clk;

    // Cycle stamp of every match pulse, seen one edge late by the tasks
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (periodMatch === 1'b1) begin
            matchCnt  <= matchCnt + 1;
            lastMatch <= cyc;
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task wr(input logic [2:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wrEn  <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [2:0] a, output logic [7:0] d);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        d = rdata;
        @(posedge clk);
    endtask

    task rdChk(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] r;
        rd(a, r);
        check(r, e);
    endtask

    task waitMatch;
        int m0;
        m0 = matchCnt;
        for (int i = 0; i < 20000 && matchCnt == m0; i++) begin
            @(posedge clk);
        end
        if (matchCnt == m0) begin
            nErrors++;
        end
    endtask

    task summarize;
        $display("mismatches %0d, checks %0d", nErrors, checkCount);
        if (nErrors == 0 && checkCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Longest case is the prescale sweep, well inside this span
    initial begin
        repeat (60000) @(posedge clk);
        nErrors++;
        summarize();
    end

    initial begin
        {clk, reset_n, wrEn, rdEn, sleepReq, addr, wdata} = '0;
        void'($urandom(166));
        wMask  = '{8'hFF, 8'hFF, 8'h7F, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
        expReg = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int a = 0; a < 8; a++) begin
            rdChk(3'(a), expReg[a]);
        end
        // Control written with run off so the count cannot move
        for (int a = 0; a < 8; a++) begin
            w = 8'($urandom);
            if (a == 2) w = (w & 8'hFB) | 8'h80;
            wr(3'(a), w);
            expReg[a] = w & wMask[a];
        end
        repeat (100) @(posedge clk);
        for (int a = 0; a < 8; a++) begin
            rdChk(3'(a), expReg[a]);
        end
        for (int s = 0; s < 4; s++) begin
            p = $urandom_range(4, 1);
            // Stop first so no pulse of the old setting is counted late
            wr(pt_pkg::ADDR_CTRL, 8'h00);
            wr(pt_pkg::ADDR_COUNT, 8'h00);
            wr(pt_pkg::ADDR_PERIOD, 8'(p));
            wr(pt_pkg::ADDR_CTRL, 8'(s) | 8'h04);
            waitMatch();
            t1 = lastMatch;
            waitMatch();
            check(lastMatch - t1, pt_pkg::INST_DIV * (1 << (2 * s)) * (p + 1));
        end
        // Count write mid-interval must restart the prescaler
        wr(pt_pkg::ADDR_COUNT, 8'h00);
        wr(pt_pkg::ADDR_PERIOD, 8'h00);
        wr(pt_pkg::ADDR_CTRL, 8'h06);
        waitMatch();
        repeat (30) @(posedge clk);
        t1 = cyc;
        wr(pt_pkg::ADDR_COUNT, 8'h00);
        waitMatch();
        check((lastMatch - t1) inside {[58:72]}, 1);
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? $urandom_range(14, 1) : 15;
            wr(pt_pkg::ADDR_CTRL, 8'h00);
            rd(pt_pkg::ADDR_FLAG, v);
            wr(pt_pkg::ADDR_COUNT, 8'h00);
            wr(pt_pkg::ADDR_PERIOD, 8'h01);
            wr(pt_pkg::ADDR_ENABLE, 8'h02);
            t1 = matchCnt;
            wr(pt_pkg::ADDR_CTRL, 8'(n << 3) | 8'h04);
            for (int i = 0; i < 2000 && irq !== 1'b1; i++) begin
                @(posedge clk);
            end
            @(posedge clk);
            check(matchCnt - t1, n + 1);
            rdChk(pt_pkg::ADDR_FLAG, 8'h02);
            check(irq, 1'b0);
            wr(pt_pkg::ADDR_ENABLE, 8'h00);
            repeat (8 * (n + 2)) @(posedge clk);
            check(irq, 1'b0);
            rdChk(pt_pkg::ADDR_FLAG, 8'h02);
        end
        wr(pt_pkg::ADDR_PERIOD, 8'hFF);
        wr(pt_pkg::ADDR_CTRL, 8'h04);
        sleepReq <= 1'b1;
        repeat (4) @(posedge clk);
        rd(pt_pkg::ADDR_COUNT, v);
        t1 = matchCnt;
        repeat (200) @(posedge clk);
        rdChk(pt_pkg::ADDR_COUNT, v);
        rdChk(pt_pkg::ADDR_PERIOD, 8'hFF);
        check(matchCnt - t1, 0);
        sleepReq <= 1'b0;
        repeat (20) @(posedge clk);
        rd(pt_pkg::ADDR_COUNT, w);
        check(w !== v, 1);
        summarize();
    end
endmodule
